// *** rtl/lpem_regs.svh ***
// Constants of the low-power entry manager: register map, fields, resets, timing.
// Assumes a 10 MHz aclk and an AXI4-Lite master with 32-bit data.
// Contract
// - Sequencer is a fully encoded state machine with three state bits.
// - A sleep request must persist over a qualification interval before acting.
// - Qualified request raises cleanup request, registered on the system clock.
// - Sleep-active rises only after cleanup done and all clock gating finished.
// - Sleep-active holds through the mode, drops only after sleep pin release or permit low.
// - Without housekeeping, cleanup request loops back internally as cleanup done.
// - Entry only with permit high and sleep pin low.
// - Permit low refuses entry and forces immediate exit from the mode.
// - Without the permit macro, permit is treated as constantly high.
// - The state machine itself drives the permit input of the hard block.
// - Sleep pin pulses shorter than the filter width are rejected as glitches.
// - Build-time options: number of gated clocks, housekeeping inclusion and permit macro inclusion.
// - Each gated clock has its own gating filter and global clock driver.
`ifndef LPEM_REGS_SVH
`define LPEM_REGS_SVH

`define LPEM_CTRL_OFS 8'h00
`define LPEM_STAT_OFS 8'h04
`define LPEM_CTRL_HK_EN_BIT 0
`define LPEM_CTRL_PERMIT_EN_BIT 1
`define LPEM_CTRL_SW_DONE_BIT 2
`define LPEM_CTRL_RST 32'h0000_0003
`define LPEM_STAT_STATE_LSB 0
`define LPEM_STAT_ACTIVE_BIT 3
`define LPEM_STAT_WAITHK_BIT 4
`define LPEM_STAT_PERMIT_BIT 5
`define LPEM_STAT_GATED_BIT 6
`define LPEM_STAT_PIN_BIT 7
// Qualification and glitch filter times, ns, with cycle counts derived
`define LPEM_CLK_NS 100
`define LPEM_QUAL_NS 1000
`define LPEM_QUAL_CYC ((`LPEM_QUAL_NS + `LPEM_CLK_NS - 1) / `LPEM_CLK_NS)
`define LPEM_GLITCH_NS 2
`define LPEM_GLITCH_CYC ((`LPEM_GLITCH_NS + `LPEM_CLK_NS - 1) / `LPEM_CLK_NS)
`define LPEM_RESP_OKAY 2'h0
`define LPEM_RESP_SLVERR 2'h2

`endif

// *** rtl/lpem_pkg.sv ***
// Types of the low-power entry manager.
// Assumes nothing beyond a SystemVerilog compiler.
package lpem_pkg;
  // Three-bit fully encoded sequencer states
  typedef enum logic [2:0] {
    LPEM_IDLE = 3'h0,
    LPEM_QUAL = 3'h1,
    LPEM_HOUSE = 3'h2,
    LPEM_GATE = 3'h3,
    LPEM_ARM = 3'h4,
    LPEM_SLEEP = 3'h5,
    LPEM_WAKE = 3'h6
  } lpem_state_t;
endpackage

// *** rtl/lpem_clock_filter.sv ***
// Glitch-free clock gating filter with a global clock driver stage.
// Assumes enable is synchronous to aclk, unrelated to source_clock.
`timescale 1ns/1ps
module lpem_clock_filter (
  input wire logic source_clock,
  input wire logic enable,
  output logic source_clock_gated
);
  logic latch_q;
  logic global_clock_driver;

  // Latch open while clock low, so enable never changes mid high phase
  always_latch begin
    if (!source_clock) begin
      latch_q = enable;
    end
  end

  // AND gate then global buffer stand-in
  assign global_clock_driver = source_clock & latch_q;
  assign source_clock_gated = global_clock_driver;
endmodule

// *** rtl/lpem_low_power_entry_manager.sv ***
// Low-power entry sequencer with AXI4-Lite control/status and clock gating.
// Assumes sleep_pin comes straight from a top-level input, synchronous to aclk.
`timescale 1ns/1ps
`include "lpem_regs.svh"
module lpem_low_power_entry_manager #(
  parameter int NUM_GATED = 2,
  parameter bit HOUSEKEEPING = 1'b1,
  parameter bit PERMIT_MACRO = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_pin_n,
  input wire logic cleanup_done,
  output logic cleanup_req,
  output logic sleep_active,
  output logic sleep_permit,
  output logic clocks_gated,
  input wire logic [NUM_GATED-1:0] source_clock,
  output logic [NUM_GATED-1:0] source_clock_gated,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  lpem_pkg::lpem_state_t state_reg, state_next;
  logic [3:0] glitch_cnt_reg;
  logic pin_filt_reg; // Filtered request, high means sleep asked
  logic [3:0] qual_cnt_reg;
  logic [2:0] ctrl_reg;
  logic [NUM_GATED-1:0] gate_en_reg;
  logic cleanup_req_reg, sleep_active_reg, permit_reg, gated_reg;
  logic aw_held_reg, w_held_reg;
  logic awready_reg, wready_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg, arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg;

  // Count helper shared by the glitch filter and qualification timer
  function automatic logic [3:0] count_up(input logic [3:0] c, input logic [3:0] lim);
    count_up = (c >= lim) ? c : c + 4'h1;
  endfunction

  // Address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == `LPEM_CTRL_OFS) || (a == `LPEM_STAT_OFS);
  endfunction

  wire sleep_req_raw = ~sleep_pin_n;
  wire [3:0] glitch_lim = 4'(`LPEM_GLITCH_CYC);
  wire [3:0] qual_lim = 4'(`LPEM_QUAL_CYC);
  wire hk_on = HOUSEKEEPING && ctrl_reg[`LPEM_CTRL_HK_EN_BIT];
  // Without the handshake the request folds back as its own done
  wire done_in = hk_on ? (cleanup_done | ctrl_reg[`LPEM_CTRL_SW_DONE_BIT])
                       : cleanup_req_reg;
  // Absent macro means permit reads as always high
  wire permit_ok = PERMIT_MACRO ? ctrl_reg[`LPEM_CTRL_PERMIT_EN_BIT] : 1'b1;
  wire qual_done = qual_cnt_reg >= qual_lim;
  wire gate_all_off = (gate_en_reg == '0);

  // Glitch filter: input must hold a full filter width before it changes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      glitch_cnt_reg <= 4'h0;
      pin_filt_reg <= 1'b0;
    end else if (sleep_req_raw == pin_filt_reg) begin
      glitch_cnt_reg <= 4'h0;
    end else begin
      glitch_cnt_reg <= count_up(glitch_cnt_reg, glitch_lim);
      if (glitch_cnt_reg + 4'h1 >= glitch_lim) begin
        pin_filt_reg <= sleep_req_raw;
      end
    end
  end

  // Qualification timer runs only in the qualify state
  always_ff @(posedge aclk) begin
    if (!aresetn || state_reg != lpem_pkg::LPEM_QUAL) begin
      qual_cnt_reg <= 4'h0;
    end else begin
      qual_cnt_reg <= count_up(qual_cnt_reg, qual_lim);
    end
  end

  // Sequencer next state; a released pin always unwinds orderly
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      lpem_pkg::LPEM_IDLE: begin
        if (pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_QUAL;
        end
      end
      lpem_pkg::LPEM_QUAL: begin
        if (!pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_IDLE;
        end else if (qual_done) begin
          state_next = lpem_pkg::LPEM_HOUSE;
        end
      end
      lpem_pkg::LPEM_HOUSE: begin
        if (!pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_IDLE;
        end else if (done_in) begin
          state_next = lpem_pkg::LPEM_GATE;
        end
      end
      lpem_pkg::LPEM_GATE: begin
        if (!pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_WAKE;
        end else if (gate_all_off) begin
          state_next = lpem_pkg::LPEM_ARM;
        end
      end
      lpem_pkg::LPEM_ARM: begin
        if (!pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_WAKE;
        end else if (permit_ok) begin
          state_next = lpem_pkg::LPEM_SLEEP;
        end
      end
      lpem_pkg::LPEM_SLEEP: begin
        if (!pin_filt_reg) begin
          state_next = lpem_pkg::LPEM_WAKE;
        end else if (!permit_ok) begin
          state_next = lpem_pkg::LPEM_ARM;
        end
      end
      lpem_pkg::LPEM_WAKE: begin
        state_next = lpem_pkg::LPEM_IDLE;
      end
      default: begin
        state_next = lpem_pkg::LPEM_IDLE;
      end
    endcase
  end

  // Fully encoded three-bit state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= lpem_pkg::LPEM_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decode of the state being entered, so outputs line up with it
  wire in_house = (state_next == lpem_pkg::LPEM_HOUSE);
  wire in_sleep = (state_next == lpem_pkg::LPEM_SLEEP);
  // Gates close from GATE onward and reopen in WAKE or IDLE
  wire gate_close = (state_next == lpem_pkg::LPEM_GATE) ||
                    (state_next == lpem_pkg::LPEM_ARM) || in_sleep;
  // Permit only asserted once clocks are stopped, never from user logic
  wire permit_next = in_sleep && permit_ok;

  // Registered handshake and status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cleanup_req_reg <= 1'b0;
      sleep_active_reg <= 1'b0;
      permit_reg <= 1'b0;
      gated_reg <= 1'b0;
      gate_en_reg <= '1;
    end else begin
      cleanup_req_reg <= in_house;
      sleep_active_reg <= in_sleep && gate_all_off;
      permit_reg <= permit_next;
      gate_en_reg <= {NUM_GATED{~gate_close}};
      gated_reg <= gate_all_off;
    end
  end

  assign cleanup_req = cleanup_req_reg;
  assign sleep_active = sleep_active_reg;
  assign sleep_permit = permit_reg;
  assign clocks_gated = gated_reg;

  // One gating filter per gated clock
  for (genvar i = 0; i < NUM_GATED; i++) begin : g_filter
    lpem_clock_filter u_filter (
      .source_clock(source_clock[i]),
      .enable(gate_en_reg[i]),
      .source_clock_gated(source_clock_gated[i])
    );
  end

  // AXI4-Lite write path: address and data taken in either order
  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire wr_go = aw_held_reg && w_held_reg && !bvalid_reg;
  wire wr_hit = reg_hit(awaddr_reg);
  wire ctrl_wr = wr_go && (awaddr_reg == `LPEM_CTRL_OFS) && wstrb_reg[0];
  // Next values let both readies come straight from flops
  wire aw_held_next = wr_go ? 1'b0 : (aw_take | aw_held_reg);
  wire w_held_next = wr_go ? 1'b0 : (w_take | w_held_reg);
  wire bvalid_next = wr_go | (bvalid_reg & ~s_axi_bready);

  // Holding flags; a ready stays low while its half is parked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      awready_reg <= !aw_held_next && !bvalid_next;
      wready_reg <= !w_held_next && !bvalid_next;
    end
  end

  // Payload capture at the accepting edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  // Response and control update once both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `LPEM_RESP_OKAY;
      ctrl_reg <= 3'(`LPEM_CTRL_RST);
    end else begin
      bvalid_reg <= bvalid_next;
      if (wr_go) begin
        bresp_reg <= wr_hit ? `LPEM_RESP_OKAY : `LPEM_RESP_SLVERR;
      end
      if (ctrl_wr) begin
        ctrl_reg <= wdata_reg[2:0]; // Status writes are dropped
      end
    end
  end

  // Bus outputs straight from their flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // Status word shows the sequencer's live state
  wire [31:0] stat_word;
  // Field positions follow the status bit constants
  assign stat_word[31:8] = 24'h00_0000;
  assign stat_word[`LPEM_STAT_PIN_BIT] = ~sleep_pin_n;
  assign stat_word[`LPEM_STAT_GATED_BIT] = gated_reg;
  assign stat_word[`LPEM_STAT_PERMIT_BIT] = permit_reg;
  assign stat_word[`LPEM_STAT_WAITHK_BIT] = cleanup_req_reg;
  assign stat_word[`LPEM_STAT_ACTIVE_BIT] = sleep_active_reg;
  assign stat_word[`LPEM_STAT_STATE_LSB +: 3] = state_reg;
  wire [31:0] rd_word = (s_axi_araddr == `LPEM_CTRL_OFS) ? {29'h0, ctrl_reg} : stat_word;
  wire rd_hit = reg_hit(s_axi_araddr);

  // Read path: one cycle address accept, data in the following cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= `LPEM_RESP_OKAY;
    end else begin
      arready_reg <= s_axi_arvalid && !arready_reg && !rvalid_reg;
      if (s_axi_arvalid && arready_reg) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_hit ? rd_word : 32'h0000_0000;
        rresp_reg <= rd_hit ? `LPEM_RESP_OKAY : `LPEM_RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
endmodule

// *** verification/lpem_low_power_entry_manager_asserts.sv ***
// Checker for the sequencing outputs of the low-power entry manager.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module lpem_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_pin_n,
  input wire logic cleanup_req,
  input wire logic sleep_active,
  input wire logic sleep_permit,
  input wire logic clocks_gated
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Request stays quiet while the pin is still being qualified
  AST_QUAL_HOLD: assert property ($fell(sleep_pin_n) |=> !cleanup_req [*8])
    else $error("cleanup request before qualification ended");
  AST_GLITCH: assert property (sleep_pin_n ##1 !sleep_pin_n ##1 sleep_pin_n |=> !cleanup_req [*8])
    else $error("one-cycle pin dip was acted on");
  AST_REQ_CAUSE: assert property ($rose(cleanup_req) |-> !sleep_pin_n && $past(sleep_pin_n, 10) == 1'b0)
    else $error("cleanup request without a held pin request");
  // Entry needs finished gating, permit and a low pin
  AST_ACTIVE_GATED: assert property ($rose(sleep_active) |-> clocks_gated && $past(clocks_gated) && !cleanup_req)
    else $error("sleep active before gating finished");
  AST_ENTRY_COND: assert property ($rose(sleep_active) |-> sleep_permit && !sleep_pin_n)
    else $error("entry without permit or pin request");
  AST_PERMIT_TIE: assert property (sleep_active |-> sleep_permit)
    else $error("sleep active while permit low");
  AST_ACTIVE_HOLD: assert property (sleep_active && !sleep_pin_n |=> sleep_active || !sleep_permit)
    else $error("sleep active dropped while pin held");
  AST_WAKE_EXIT: assert property ($rose(sleep_pin_n) && sleep_active |-> ##[1:4] !sleep_active)
    else $error("sleep active stuck after pin release");
endmodule
bind lpem_low_power_entry_manager lpem_asserts i_chk (
  .aclk, .aresetn, .sleep_pin_n, .cleanup_req, .sleep_active, .sleep_permit, .clocks_gated
);

// *** verification/lpem_housekeeper.sv ***
// Model of the user housekeeping logic facing the entry manager.
// Assumes cleanup_req is a level held until done is seen.
`timescale 1ns/1ps
module lpem_housekeeper (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] delay,
  input wire logic cleanup_req,
  output logic cleanup_done
);
  logic [3:0] wait_reg;
  // Shutdown work takes delay cycles; done drops with the request
  always_ff @(posedge aclk) begin
    if (!aresetn || !cleanup_req) begin
      wait_reg <= 4'h0;
      cleanup_done <= 1'b0;
    end else if (wait_reg == delay) begin
      cleanup_done <= 1'b1;
    end else begin
      wait_reg <= wait_reg + 4'h1;
    end
  end
endmodule

// *** verification/lpem_low_power_entry_manager_test.sv ***
// Self-checking bench for the low-power entry manager.
// Assumes the housekeeping model on the far side and a 10 MHz aclk.
`timescale 1ns/1ps
`include "lpem_regs.svh"
module lpem_low_power_entry_manager_test;
  logic aclk, aresetn, sleep_pin_n, cleanup_done, cleanup_req;
  logic sleep_active, sleep_permit, clocks_gated;
  logic [1:0] source_clock, source_clock_gated, s_axi_bresp, s_axi_rresp;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, hk_delay;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int failures, samples_checked, cycles;
  int gated_edges, edge_mark;
  logic pin_only_active;
  lpem_low_power_entry_manager i_dut (
    .aclk, .aresetn, .sleep_pin_n, .cleanup_done, .cleanup_req, .sleep_active, .sleep_permit,
    .clocks_gated, .source_clock, .source_clock_gated, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  lpem_housekeeper i_hk (.aclk, .aresetn, .delay(hk_delay), .cleanup_req, .cleanup_done);
  // Pin-only build: no permit block, no handshake, done input unused
  lpem_low_power_entry_manager #(.HOUSEKEEPING(1'b0), .PERMIT_MACRO(1'b0)) i_dut_pin (
    .aclk, .aresetn, .sleep_pin_n, .cleanup_done(1'b0), .cleanup_req(),
    .sleep_active(pin_only_active), .sleep_permit(), .clocks_gated(), .source_clock,
    .source_clock_gated(), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready
  );
  // Edge count on the gated clocks tells running from stopped
  always @(posedge source_clock_gated[0] or posedge source_clock_gated[1]) gated_edges++;
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // Source clocks unrelated to aclk, so gating is seen at odd phases
  always #30 source_clock[0] = ~source_clock[0];
  always #45 source_clock[1] = ~source_clock[1];
  // Hang guard, about five times the expected run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 1000) begin
      failures++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write master: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, er);
    // Idle edge keeps this release apart from the next request
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, e);
    chk(s_axi_rresp, er);
    @(posedge aclk);
  endtask
  // Bounded wait for sleep_active to reach a level
  task automatic settle(input logic v, input int n);
    repeat (n) if (sleep_active !== v) @(posedge aclk);
  endtask
  initial begin
    aresetn = 1'b0;
    sleep_pin_n = 1'b1;
    source_clock = 2'b00;
    hk_delay = 4'h6;
    s_axi_wstrb = 4'hF;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Register map: reset values, read-only status, unmapped places
    rd(`LPEM_CTRL_OFS, `LPEM_CTRL_RST, 32'hFFFF_FFFF, `LPEM_RESP_OKAY);
    rd(`LPEM_STAT_OFS, 32'h0, 32'h7F, `LPEM_RESP_OKAY);
    rd(8'h08, 32'h0, 32'hFFFF_FFFF, `LPEM_RESP_SLVERR);
    wr(8'h0C, 32'h0, `LPEM_RESP_SLVERR);
    wr(`LPEM_STAT_OFS, 32'hFFFF_FFFF, `LPEM_RESP_OKAY);
    rd(`LPEM_STAT_OFS, 32'h0, 32'h7F, `LPEM_RESP_OKAY);
    // One-cycle dip, then a hold shorter than qualification
    sleep_pin_n <= 1'b0;
    @(posedge aclk);
    sleep_pin_n <= 1'b1;
    repeat (15) @(posedge aclk);
    chk(cleanup_req, 1'b0);
    sleep_pin_n <= 1'b0;
    repeat (6) @(posedge aclk);
    sleep_pin_n <= 1'b1;
    repeat (15) @(posedge aclk);
    chk(cleanup_req, 1'b0);
    // Full entry with a slow housekeeper
    sleep_pin_n <= 1'b0;
    repeat (10) @(posedge aclk);
    chk(cleanup_req, 1'b0);
    repeat (6) @(posedge aclk);
    chk(cleanup_req, 1'b1);
    chk(sleep_active, 1'b0);
    settle(1'b1, 30);
    chk(clocks_gated, 1'b1);
    chk(sleep_permit, 1'b1);
    chk(pin_only_active, 1'b1);
    edge_mark = gated_edges;
    repeat (5) @(posedge aclk);
    chk(source_clock_gated, 2'b00);
    chk(gated_edges, edge_mark);
    rd(`LPEM_STAT_OFS, {29'h0, lpem_pkg::LPEM_SLEEP}, 32'h7, `LPEM_RESP_OKAY);
    // Permit withdrawn forces exit, restored permit re-enters
    wr(`LPEM_CTRL_OFS, 32'h1, `LPEM_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk(sleep_active, 1'b0);
    chk(sleep_permit, 1'b0);
    chk(pin_only_active, 1'b1);
    wr(`LPEM_CTRL_OFS, 32'h3, `LPEM_RESP_OKAY);
    settle(1'b1, 10);
    chk(sleep_active, 1'b1);
    repeat (20) @(posedge aclk);
    chk(sleep_active, 1'b1);
    sleep_pin_n <= 1'b1;
    settle(1'b0, 6);
    chk(sleep_active, 1'b0);
    repeat (4) @(posedge aclk);
    chk(clocks_gated, 1'b0);
    chk(gated_edges > edge_mark, 1'b1);
    // Housekeeping off: entry must not wait for the slow housekeeper
    wr(`LPEM_CTRL_OFS, 32'h2, `LPEM_RESP_OKAY);
    hk_delay <= 4'hF;
    sleep_pin_n <= 1'b0;
    repeat (24) @(posedge aclk);
    chk(sleep_active, 1'b1);
    sleep_pin_n <= 1'b1;
    settle(1'b0, 6);
    chk(sleep_active, 1'b0);
    // Software done bit stands in for the slow housekeeper
    wr(`LPEM_CTRL_OFS, 32'h7, `LPEM_RESP_OKAY);
    sleep_pin_n <= 1'b0;
    repeat (24) @(posedge aclk);
    chk(sleep_active, 1'b1);
    sleep_pin_n <= 1'b1;
    settle(1'b0, 6);
    chk(sleep_active, 1'b0);
    end_sim();
  end
endmodule
